// File: dv/event_source.sv
`timescale 1ns/1ps
`default_nettype none

// outside world: the capture input pin and the external timebase clock pin
module event_source (
    input wire logic clk_sys,
    output var logic event_pin,
    output var logic ext_clk
);
    // both lines are always driven and start low; ext_clk rests low between actions, event_pin stays where set_pin left it
    initial begin
        event_pin = 1'b0;
        ext_clk = 1'b0;
    end

    // move the pin, then hold it long enough for the two-flop sync
    task automatic set_pin(input logic lvl);
        @(posedge clk_sys);
        event_pin <= lvl;
        repeat (4) @(posedge clk_sys);
    endtask

    // one high pulse, so exactly one rising edge
    task automatic rise_pulse();
        set_pin(1'b1);
        set_pin(1'b0);
    endtask

    // slow external timebase clock, a sampled counter, never system rate
    task automatic ext_ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
endmodule // event_source

`default_nettype wire

// File: dv/input_capture_prescaled_test.sv
`timescale 1ns/1ps
`default_nettype none

module input_capture_prescaled_test;
    import capture_pkg::*;

    logic clk_sys, arst_n, hsel, hwrite, sleep_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq, pin, ext_clk;
    int fails, n_compared;
    logic [31:0] rd_a, rd_b, rd_c; // timebase samples around sleep

    // hready of the bus is the single slave's hreadyout
    input_capture_prescaled dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .event_input_pin(pin), .ext_clk_pin(ext_clk), .sleep_req(sleep_req), .irq(irq));
    event_source src_u (.clk_sys(clk_sys), .event_pin(pin), .ext_clk(ext_clk));

    // 250 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // four-state compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            fails++;
            $display("wrong value at %0t ns: bus never ready", $time);
            tally_and_finish();
        end
    endtask

    // one single ahb-lite word transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(a, 1'b1, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(a, 1'b0, 32'h0000_0000, d);
        chk(d, exp);
    endtask

    // irq is looked at one edge later, once the register write has landed
    task automatic irq_chk(input logic exp);
        @(posedge clk_sys);
        chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask

    // new mode in one write, then drop any false flag the change raised
    task automatic enter(input logic [3:0] m);
        wr(OFF_CONTROL, {28'h000_0000, m});
        repeat (4) @(posedge clk_sys);
        bus(OFF_STATUS, 1'b0, 32'h0000_0000, rd_c);
    endtask

    // module off first, so the prescaler starts from zero
    task automatic restart(input logic [3:0] m);
        wr(OFF_CONTROL, 32'h0000_0000);
        enter(m);
    endtask

    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        sleep_req = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped word, read-only status
        for (int a = 0; a <= 32; a += 4) rd_chk(8'(a), 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFF5);
        rd_chk(8'h20, 32'h0000_0000);
        wr(OFF_STATUS, 32'h0000_0001);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        wr(OFF_CONTROL, 32'hFFFF_FFF5);
        rd_chk(OFF_CONTROL, 32'h0000_00F5);
        $display("test registers done");
        // frozen external timebase gives an exact captured value
        wr(OFF_TB_CFG, 32'h0000_0003);
        wr(OFF_TB_LOW, 32'h0000_00FE);
        wr(OFF_TB_HIGH, 32'h0000_0012);
        restart(MODE_CAP_RISE);
        src_u.rise_pulse();
        irq_chk(1'b0);
        wr(OFF_MASK, 32'h0000_0001);
        irq_chk(1'b1);
        rd_chk(OFF_CAP_LOW, 32'h0000_00FE);
        rd_chk(OFF_CAP_HIGH, 32'h0000_0012);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        irq_chk(1'b0);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        wr(OFF_MASK, 32'h0000_0000);
        $display("test capture done");
        // off to falling with the pin low gives a false flag
        wr(OFF_CONTROL, 32'h0000_0000);
        wr(OFF_CONTROL, {28'h000_0000, MODE_CAP_FALL});
        repeat (4) @(posedge clk_sys);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        src_u.set_pin(1'b1);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        src_u.set_pin(1'b0);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        src_u.ext_ticks(3);
        rd_chk(OFF_TB_LOW, 32'h0000_0001);
        rd_chk(OFF_TB_HIGH, 32'h0000_0013);
        src_u.rise_pulse();
        rd_chk(OFF_CAP_LOW, 32'h0000_0001);
        rd_chk(OFF_CAP_HIGH, 32'h0000_0013);
        $display("test falling done");
        // divided settings fire on every 4th or 16th rising edge, then wrap
        for (int i = 0; i < 2; i++) begin
            restart(i == 0 ? MODE_CAP_DIV4 : MODE_CAP_DIV16);
            for (int k = 1; k <= (i == 0 ? 8 : 32); k++) begin
                src_u.rise_pulse();
                rd_chk(OFF_STATUS, {31'h0000_0000, k % (i == 0 ? 4 : 16) == 0});
            end
        end
        $display("test prescaler done");
        // module off, non-capture code and reset each empty the prescaler
        for (int m = 0; m < 3; m++) begin
            restart(MODE_CAP_DIV4);
            src_u.rise_pulse();
            src_u.rise_pulse();
            if (m == 0) begin
                wr(OFF_CONTROL, 32'h0000_0000);
            end else if (m == 1) begin
                wr(OFF_CONTROL, 32'h0000_0008);
            end else begin
                arst_n <= 1'b0;
                repeat (2) @(posedge clk_sys);
                arst_n <= 1'b1;
                @(posedge clk_sys);
            end
            enter(MODE_CAP_DIV4);
            for (int k = 1; k <= 4; k++) begin
                src_u.rise_pulse();
                rd_chk(OFF_STATUS, {31'h0000_0000, k == 4});
            end
        end
        $display("test prescaler clear done");
        // direct switch from 16th to 4th keeps the count of five
        restart(MODE_CAP_DIV16);
        repeat (5) src_u.rise_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0000);
        enter(MODE_CAP_DIV4);
        src_u.rise_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0001);
        $display("test prescaler switch done");
        // sleep on the internal clock: count held, no capture
        wr(OFF_TB_CFG, 32'h0000_0001);
        restart(MODE_CAP_RISE);
        sleep_req <= 1'b1;
        bus(OFF_TB_LOW, 1'b0, 32'h0000_0000, rd_a);
        repeat (20) @(posedge clk_sys);
        bus(OFF_TB_LOW, 1'b0, 32'h0000_0000, rd_b);
        chk(rd_b, rd_a);
        src_u.rise_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0000);
        sleep_req <= 1'b0;
        repeat (40) @(posedge clk_sys);
        bus(OFF_TB_LOW, 1'b0, 32'h0000_0000, rd_c);
        // forty awake system clocks are exactly ten instruction ticks
        chk(rd_c, {24'h00_0000, rd_a[7:0] + 8'h0A});
        // sleep on the external clock: counting and capture go on
        wr(OFF_TB_CFG, 32'h0000_0003);
        wr(OFF_TB_LOW, 32'h0000_0055);
        wr(OFF_TB_HIGH, 32'h0000_0066);
        sleep_req <= 1'b1;
        src_u.ext_ticks(2);
        src_u.rise_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0001);
        rd_chk(OFF_CAP_LOW, 32'h0000_0057);
        rd_chk(OFF_CAP_HIGH, 32'h0000_0066);
        sleep_req <= 1'b0;
        $display("test sleep done");
        tally_and_finish();
    end
endmodule // input_capture_prescaled_test

`default_nettype wire

// File: verilog/capture_pkg.sv
`default_nettype none

package capture_pkg;

    // byte offsets of the register words
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CAP_LOW = 8'h04;
    localparam logic [7:0] OFF_CAP_HIGH = 8'h08;
    localparam logic [7:0] OFF_TB_LOW = 8'h0C;
    localparam logic [7:0] OFF_TB_HIGH = 8'h10;
    localparam logic [7:0] OFF_TB_CFG = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1C;

    // mode field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_DIV4 = 4'h6;
    localparam logic [3:0] MODE_CAP_DIV16 = 4'h7;
    localparam logic [1:0] MODE_CAP_GROUP = 2'h1;

    // prescaler terminal counts and the zero it wraps to
    localparam logic [3:0] PRESC_DIV4_LAST = 4'h3;
    localparam logic [3:0] PRESC_DIV16_LAST = 4'hF;
    localparam logic [3:0] PRESC_ZERO = 4'h0;

    // instruction clock is system clock divided by four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // control register layout
    typedef struct packed {
        logic [1:0] bridge_output_config;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_field;
    } unit_ctrl_s;

    // timebase source and run bits
    typedef struct packed {
        logic ext_source;
        logic timebase_on;
    } tb_cfg_s;

    localparam unit_ctrl_s CTRL_RESET = 8'h00;
    localparam tb_cfg_s TB_CFG_RESET = 2'h0;
    localparam logic [15:0] WORD16_ZERO = 16'h0000;
    localparam logic [15:0] WORD16_ONE = 16'h0001;
    localparam logic [31:0] WORD32_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire

// File: verilog/input_capture_prescaled.sv
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module input_capture_prescaled
    import capture_pkg::*;
#(
    parameter bit ENHANCED = 1'b1 // bridge bits kept only when set
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic event_input_pin,
    input wire logic ext_clk_pin,
    input wire logic sleep_req,
    output logic irq
);

    // bus bookkeeping
    logic addr_take; // address phase accepted this edge
    logic addr_ok; // aligned word address in the lowest 256 bytes, mapped or not
    logic wr_pend_reg; // a write data phase is running
    logic [7:0] wr_addr_reg; // its address
    logic [31:0] hrdata_reg; // read answer, loaded at the address edge
    logic [31:0] rd_mux; // read value chosen combinationally
    logic status_rd; // status read in address phase: clears flag

    // write strobes, valid in the data phase
    logic wr_ctrl;
    logic wr_cap_low;
    logic wr_cap_high;
    logic wr_tb_low;
    logic wr_tb_high;
    logic wr_tb_cfg;
    logic wr_mask;
    logic tb_wr; // either timebase byte written

    // registers seen by software
    unit_ctrl_s ctrl_reg; // unit_control_register
    unit_ctrl_s ctrl_next;
    tb_cfg_s tb_cfg_reg;
    logic [15:0] timebase_reg; // timebase_counter
    logic [15:0] captured_reg; // captured_value_high:captured_value_low
    logic event_flag_reg;
    logic event_irq_enable_reg;

    // capture path
    logic pin_meta_reg; // first sync flop, read only by the second
    logic pin_sync_reg;
    logic sel_prev_reg; // polarity-adjusted level one cycle ago
    logic sel_level;
    logic in_capture;
    logic edge_raw;
    logic edge_q; // qualified edge with clocks alive
    logic [3:0] presc_reg;
    logic [3:0] presc_last;
    logic divided;
    logic presc_hit;
    logic cap_fire;

    // timebase clocking
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic ext_rise;
    logic [1:0] instr_div_reg;
    logic instr_tick;
    logic tb_tick;
    logic clocks_alive;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_reg;

    assign addr_take = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    assign status_rd = addr_take && !hwrite && addr_ok && (haddr[7:0] == OFF_STATUS);

    // write address latched for the following data phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_take && hwrite && addr_ok;
            wr_addr_reg <= haddr[7:0];
        end
    end

    assign wr_ctrl = wr_pend_reg && (wr_addr_reg == OFF_CONTROL);
    assign wr_cap_low = wr_pend_reg && (wr_addr_reg == OFF_CAP_LOW);
    assign wr_cap_high = wr_pend_reg && (wr_addr_reg == OFF_CAP_HIGH);
    assign wr_tb_low = wr_pend_reg && (wr_addr_reg == OFF_TB_LOW);
    assign wr_tb_high = wr_pend_reg && (wr_addr_reg == OFF_TB_HIGH);
    assign wr_tb_cfg = wr_pend_reg && (wr_addr_reg == OFF_TB_CFG);
    assign wr_mask = wr_pend_reg && (wr_addr_reg == OFF_MASK);
    assign tb_wr = wr_tb_low || wr_tb_high;

    // read mux; unmapped words and upper bits read zero
    always_comb begin
        rd_mux = WORD32_ZERO;
        if (addr_ok) begin
            unique case (haddr[7:0])
                OFF_CONTROL: rd_mux[7:0] = ctrl_reg;
                OFF_CAP_LOW: rd_mux[7:0] = captured_reg[7:0];
                OFF_CAP_HIGH: rd_mux[7:0] = captured_reg[15:8];
                OFF_TB_LOW: rd_mux[7:0] = timebase_reg[7:0];
                OFF_TB_HIGH: rd_mux[7:0] = timebase_reg[15:8];
                OFF_TB_CFG: rd_mux[1:0] = tb_cfg_reg;
                OFF_STATUS: rd_mux[0] = event_flag_reg;
                OFF_MASK: rd_mux[0] = event_irq_enable_reg;
                default: rd_mux = WORD32_ZERO; // unmapped word
            endcase
        end
    end

    // answer registered so it stands through the data phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_reg <= WORD32_ZERO;
        end else if (addr_take && !hwrite) begin
            hrdata_reg <= rd_mux;
        end
    end

    // bridge bits exist only on the enhanced variant
    always_comb begin
        ctrl_next = hwdata[7:0];
        if (!ENHANCED) begin
            ctrl_next.bridge_output_config = 2'h0;
        end
    end

    // control register, full byte written at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // timebase source selection and run bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tb_cfg_reg <= TB_CFG_RESET;
        end else if (wr_tb_cfg) begin
            tb_cfg_reg <= hwdata[1:0];
        end
    end

    // interrupt enable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_irq_enable_reg <= 1'b0;
        end else if (wr_mask) begin
            event_irq_enable_reg <= hwdata[0];
        end
    end

    // external clock pin: two flops, then edge history
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clk_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_rise = ext_sync_reg && !ext_prev_reg;

    // instruction clock divider; stops while asleep, like the oscillator
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            instr_div_reg <= 2'h0;
        end else if (!sleep_req) begin
            instr_div_reg <= instr_div_reg + 2'h1;
        end
    end

    assign instr_tick = (instr_div_reg == INSTR_DIV_LAST) && !sleep_req;
    // system-clock-rate ticking is not offered at all: it would outrun capture
    assign tb_tick = tb_cfg_reg.timebase_on && (tb_cfg_reg.ext_source ? ext_rise : instr_tick);
    // with the instruction clock asleep and driving the timebase, nothing is sampled
    assign clocks_alive = !sleep_req || tb_cfg_reg.ext_source;

    // 16-bit count; a byte write takes priority over the tick
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            timebase_reg <= WORD16_ZERO;
        end else if (wr_tb_low) begin
            timebase_reg[7:0] <= hwdata[7:0];
        end else if (wr_tb_high) begin
            timebase_reg[15:8] <= hwdata[7:0];
        end else if (tb_tick) begin
            timebase_reg <= timebase_reg + WORD16_ONE;
        end
    end

    // pin synchroniser; same clock as the timebase, so the copy is coherent
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= event_input_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign in_capture = (ctrl_reg.unit_mode_field[3:2] == MODE_CAP_GROUP);
    // polarity is applied before the edge detector; flipping it can fake an edge
    assign sel_level = (ctrl_reg.unit_mode_field == MODE_CAP_FALL) ? !pin_sync_reg : pin_sync_reg;

    // history of the polarity-adjusted level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg <= sel_level;
        end
    end

    assign edge_raw = sel_level && !sel_prev_reg;
    assign edge_q = edge_raw && in_capture && clocks_alive;

    assign divided = (ctrl_reg.unit_mode_field == MODE_CAP_DIV4)
        || (ctrl_reg.unit_mode_field == MODE_CAP_DIV16);
    assign presc_last = (ctrl_reg.unit_mode_field == MODE_CAP_DIV16)
        ? PRESC_DIV16_LAST : PRESC_DIV4_LAST;
    // greater-or-equal: a count kept from div16 fires at once under div4
    assign presc_hit = divided && (presc_reg >= presc_last);
    assign cap_fire = edge_q && (!divided || presc_hit);

    // prescaler event counter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            presc_reg <= PRESC_ZERO;
        end else if (!in_capture) begin
            presc_reg <= PRESC_ZERO;
        end else if (edge_q && divided) begin
            if (presc_hit) begin
                presc_reg <= PRESC_ZERO;
            end else begin
                presc_reg <= presc_reg + 4'h1;
            end
        end
        // a switch between capture settings leaves the count alone
    end

    // captured pair; a capture beats a software byte write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            captured_reg <= WORD16_ZERO;
        end else if (cap_fire) begin
            captured_reg <= timebase_reg;
        end else if (wr_cap_low) begin
            captured_reg[7:0] <= hwdata[7:0];
        end else if (wr_cap_high) begin
            captured_reg[15:8] <= hwdata[7:0];
        end
    end

    // sticky flag; read clears, a same-cycle capture wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_flag_reg <= 1'b0;
        end else if (cap_fire) begin
            event_flag_reg <= 1'b1;
        end else if (status_rd) begin
            event_flag_reg <= 1'b0;
        end
    end

    // level interrupt, software masks it during mode changes
    assign irq = event_flag_reg && event_irq_enable_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_capture_copy;
        cap_fire |=> (captured_reg == $past(timebase_reg));
    endproperty
    a_capture_copy: assert property (p_capture_copy)
        else $error("captured pair does not hold the timebase");
    property p_flag_set;
        cap_fire |=> event_flag_reg ##1 (event_flag_reg || $past(status_rd));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event flag not set by capture");
    property p_flag_clear;
        (status_rd && !cap_fire) |=> !event_flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("status read did not clear the flag");
    property p_presc_off;
        !in_capture |=> (presc_reg == PRESC_ZERO);
    endproperty
    a_presc_off: assert property (p_presc_off)
        else $error("prescaler not cleared outside capture");
    property p_div_wrap;
        (edge_q && divided && presc_reg == presc_last)
            |-> cap_fire ##1 (presc_reg == PRESC_ZERO);
    endproperty
    a_div_wrap: assert property (p_div_wrap)
        else $error("divided setting did not capture and wrap");
    property p_div4_count;
        (ctrl_reg.unit_mode_field == MODE_CAP_DIV4 && edge_q && presc_reg < PRESC_DIV4_LAST)
            |-> !cap_fire ##1 (presc_reg == $past(presc_reg) + 4'h1);
    endproperty
    a_div4_count: assert property (p_div4_count)
        else $error("div4 prescaler miscounted");
    // looks at the flag, so the whole path from edge to flag is covered
    property p_each_edge;
        (edge_q && !divided) |=> event_flag_reg;
    endproperty
    a_each_edge: assert property (p_each_edge)
        else $error("single-edge setting missed a capture");
    property p_switch_keeps;
        (in_capture && !edge_q && wr_ctrl && ctrl_next.unit_mode_field[3:2] == MODE_CAP_GROUP)
            |=> $stable(presc_reg);
    endproperty
    a_switch_keeps: assert property (p_switch_keeps)
        else $error("prescaler changed on direct setting switch");
    property p_sleep_hold;
        (sleep_req && !tb_cfg_reg.ext_source && !tb_wr) |=> $stable(timebase_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("timebase moved while asleep on instruction clock");
    property p_sleep_ext;
        (sleep_req && tb_cfg_reg.ext_source && edge_raw && in_capture && !divided)
            |=> event_flag_reg;
    endproperty
    a_sleep_ext: assert property (p_sleep_ext)
        else $error("external timebase capture lost in sleep");
    property p_tb_tick;
        (tb_tick && !tb_wr) |=> (timebase_reg == $past(timebase_reg) + WORD16_ONE);
    endproperty
    a_tb_tick: assert property (p_tb_tick)
        else $error("timebase did not advance on tick");
    // bridge bits follow the write on the enhanced unit, stay zero otherwise
    property p_std_bits;
        wr_ctrl |=> (ctrl_reg.bridge_output_config == (ENHANCED ? $past(hwdata[7:6]) : 2'h0));
    endproperty
    a_std_bits: assert property (p_std_bits)
        else $error("bridge bits wrong after control write");
    property p_sync_delay;
        (in_capture && !divided && clocks_alive && ctrl_reg.unit_mode_field == MODE_CAP_RISE
            && $stable(ctrl_reg) && $rose(pin_sync_reg)) |-> cap_fire;
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchronised rising edge not captured");

endmodule // input_capture_prescaled

`default_nettype wire
